// ### include/phase_ctl_pkg.sv
`default_nettype none
package phase_ctl_pkg;
  // Phase word width and shifter depth
  localparam int unsigned PHASE_W       = 6;
  localparam logic [5:0]  PHASE_RST     = 6'h00;
  // Bus register offsets (controller side)
  localparam logic [3:0]  OFF_WORD      = 4'h0;
  localparam logic [3:0]  OFF_CTRL      = 4'h4;
  localparam logic [3:0]  OFF_STATUS    = 4'h8;
  localparam logic [3:0]  OFF_CHAIN     = 4'hc;
  // CTRL field positions
  localparam int unsigned CTRL_GO_BIT   = 0;
  localparam int unsigned CTRL_MODE_BIT = 1;
  // Timing, as printed
  localparam int unsigned SYS_PERIOD_NS = 100;
  localparam int unsigned SCK_MIN_NS    = 100;
  localparam int unsigned LES_MIN_NS    = 630;
  // Half serial clock in system cycles, rounded up, at least one
  localparam int unsigned SCK_HALF_CYC  =
    ((SCK_MIN_NS + 2 * SYS_PERIOD_NS - 1) / (2 * SYS_PERIOD_NS)) < 1 ? 1 :
    ((SCK_MIN_NS + 2 * SYS_PERIOD_NS - 1) / (2 * SYS_PERIOD_NS));
  localparam int unsigned LES_CYC       = (LES_MIN_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam logic [3:0]  HALF_CNT      = 4'(SCK_HALF_CYC);
  localparam logic [3:0]  GAP_CNT       = 4'(LES_CYC);
endpackage : phase_ctl_pkg
`default_nettype wire

// ### include/phase_ctl_if.sv
`timescale 1ns/10ps
`default_nettype none
interface phase_ctl_if;
  logic       mode_serial;   // High: serial, low: direct parallel
  logic       pin_22;        // latch_strobe or phase_bit_3
  logic       pin_23;        // serial clock or phase_bit_2
  logic       pin_24;        // shift_data_in or phase_bit_1
  logic [2:0] phase_bits_hi; // phase_bit_6..phase_bit_4
  logic       shift_data_out;

  modport device (
    input  mode_serial, pin_22, pin_23, pin_24, phase_bits_hi,
    output shift_data_out
  );
  modport host (
    output mode_serial, pin_22, pin_23, pin_24, phase_bits_hi,
    input  shift_data_out
  );
endinterface : phase_ctl_if
`default_nettype wire

// ### design/phase_shifter_device.sv
`timescale 1ns/10ps
`default_nettype none
// How it works
// - P/S high runs serial interface, strobe loads phase
// - Controller shifts six bits MSB first
// - Strobe rising edge loads shifted word
// - Serial clock ignored while strobe high
// - Chain output is input delayed six clocks
// - P/S low disables serial interface
// - Serial mode: pins are strobe, clock, data
// - Serial phase holds while strobe low
// - Parallel mode drives phase directly
// - Parallel mode: pins are bits 3,2,1
// - Serial clock period at least 100 ns
// - Strobe pulses at least 630 ns apart
module phase_shifter_device
  import phase_ctl_pkg::*;
(
  // System
  input  wire logic                        clk_sys_in,
  input  wire logic                        rst_b_in,
  // Link
  phase_ctl_if.device                      link,
  // Phase state to the RF switches
  output logic [phase_ctl_pkg::PHASE_W-1:0] phase_state_out
);
  import phase_ctl_pkg::*;

  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic [2:0] hi1_r;
  logic [2:0] hi2_r;
  logic [1:0] mode_s_r;
  logic       clk_prev_r;
  logic       le_prev_r;
  logic [PHASE_W-1:0] shreg_r;
  logic [PHASE_W-1:0] phase_r;

  ////////////////////////////////////////////////////////////////////
  // Two-flop synchronisers on every pin
  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      sync1_r  <= 3'h0;
      sync2_r  <= 3'h0;
      hi1_r    <= 3'h0;
      hi2_r    <= 3'h0;
      mode_s_r <= 2'h0;
    end
    else
    begin
      sync1_r  <= {link.pin_22, link.pin_23, link.pin_24};
      sync2_r  <= sync1_r;
      hi1_r    <= link.phase_bits_hi;
      hi2_r    <= hi1_r;
      mode_s_r <= {mode_s_r[0], link.mode_serial};
    end
  end

  // Shared pin meaning follows the mode
  wire serial_on = mode_s_r[1];
  wire le_s      = sync2_r[2];
  wire sck_s     = sync2_r[1];
  wire sdi_s     = sync2_r[0];
  wire sck_rise  = serial_on & sck_s & ~clk_prev_r;
  wire shift_en  = sck_rise & ~le_s;
  wire le_rise   = serial_on & le_s & ~le_prev_r;
  // Parallel bits: pin 22 is bit 3, 23 bit 2, 24 bit 1
  wire [PHASE_W-1:0] par_word = {hi2_r, sync2_r};

  ////////////////////////////////////////////////////////////////////
  // Edge history; only sampled signals, never the first sync stage
  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      clk_prev_r <= 1'b0;
      le_prev_r  <= 1'b0;
    end
    else
    begin
      clk_prev_r <= sck_s;
      le_prev_r  <= le_s;
    end
  end

  // Shift chain, MSB arrives first and ends at the top
  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      shreg_r <= PHASE_RST;
    else if (shift_en)
      shreg_r <= {shreg_r[PHASE_W-2:0], sdi_s};
  end

  // Phase state: latch in serial, follow pins in parallel
  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      phase_r <= PHASE_RST;
    else if (!serial_on)
      phase_r <= par_word;
    else if (le_rise)
      phase_r <= shreg_r;
  end

  assign phase_state_out     = phase_r;
  // Daisy chain: oldest bit, six clocks late
  assign link.shift_data_out = shreg_r[PHASE_W-1];
endmodule : phase_shifter_device
`default_nettype wire

// ### design/phase_shifter_host.sv
`timescale 1ns/10ps
`default_nettype none
module phase_shifter_host
  import phase_ctl_pkg::*;
(
  // System
  input  wire logic        clk_sys_in,
  input  wire logic        rst_b_in,
  // Register port
  input  wire logic [3:0]  addr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic [31:0]      rdata_out,
  // Link
  phase_ctl_if.host        link
);
  import phase_ctl_pkg::*;

  typedef enum {ST_IDLE, ST_LOW, ST_HIGH, ST_LATCH, ST_GAP} st_t;

  st_t               st_r;
  logic [PHASE_W-1:0] word_r;
  logic [PHASE_W-1:0] sh_r;
  logic              mode_r;
  logic [2:0]        bitn_r;
  logic [3:0]        cnt_r;
  logic              sck_r;
  logic              le_r;
  logic              sdo1_r;
  logic              sdo2_r;
  logic [3:0]        cap_r;
  logic [PHASE_W-1:0] chain_r;
  logic [31:0]       rdata_r;

  wire busy   = (st_r != ST_IDLE);
  wire go_wr  = wr_in & (addr_in == OFF_CTRL) & wdata_in[CTRL_GO_BIT] & ~busy;
  wire cnt_dn = (cnt_r == 4'h1);

  ////////////////////////////////////////////////////////////////////
  // Registers written by software
  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      word_r <= PHASE_RST;
      mode_r <= 1'b1;
    end
    else if (wr_in && addr_in == OFF_WORD)
      word_r <= wdata_in[PHASE_W-1:0];
    else if (wr_in && addr_in == OFF_CTRL)
      mode_r <= wdata_in[CTRL_MODE_BIT];
  end

  // Serial engine; strobe stays low while shifting
  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      st_r   <= ST_IDLE;
      sh_r   <= PHASE_RST;
      bitn_r <= 3'h0;
      cnt_r  <= 4'h0;
      sck_r  <= 1'b0;
      le_r   <= 1'b0;
    end
    else
    begin
      case (st_r)
        ST_IDLE:
        begin
          if (go_wr && mode_r)
          begin
            sh_r   <= word_r;
            bitn_r <= 3'h0;
            cnt_r  <= HALF_CNT;
            st_r   <= ST_LOW;
          end
        end
        ST_LOW:
        begin
          if (cnt_dn)
          begin
            sck_r <= 1'b1;
            cnt_r <= HALF_CNT;
            st_r  <= ST_HIGH;
          end
          else
            cnt_r <= cnt_r - 4'h1;
        end
        ST_HIGH:
        begin
          if (cnt_dn)
          begin
            sck_r  <= 1'b0;
            sh_r   <= {sh_r[PHASE_W-2:0], 1'b0};
            bitn_r <= bitn_r + 3'h1;
            cnt_r  <= HALF_CNT;
            st_r   <= (bitn_r == 3'(PHASE_W - 1)) ? ST_LATCH : ST_LOW;
          end
          else
            cnt_r <= cnt_r - 4'h1;
        end
        ST_LATCH:
        begin
          // Strobe after sixth bit, held HALF_CNT cycles (one here) for the sampler
          le_r <= 1'b1;
          if (le_r && cnt_dn)
          begin
            le_r  <= 1'b0;
            cnt_r <= GAP_CNT;
            st_r  <= ST_GAP;
          end
          else if (le_r)
            cnt_r <= cnt_r - 4'h1;
        end
        ST_GAP:
        begin
          // Spacing before another strobe may start
          if (cnt_dn)
            st_r <= ST_IDLE;
          else
            cnt_r <= cnt_r - 4'h1;
        end
        default:
          st_r <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Chain return taken four cycles after each clock rise we make: the
  // far end needs two sync stages before it shifts, and our own return
  // path adds two more, so the bit just ahead of that shift is caught
  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      sdo1_r  <= 1'b0;
      sdo2_r  <= 1'b0;
      cap_r   <= 4'h0;
      chain_r <= PHASE_RST;
    end
    else
    begin
      sdo1_r <= link.shift_data_out;
      sdo2_r <= sdo1_r;
      cap_r  <= {cap_r[2:0], (st_r == ST_LOW) && cnt_dn};
      if (cap_r[3])
        chain_r <= {chain_r[PHASE_W-2:0], sdo2_r};
    end
  end

  // Read mux, data one cycle after strobe
  wire [31:0] rd_mux =
    (addr_in == OFF_WORD)   ? {26'h0, word_r} :
    (addr_in == OFF_CTRL)   ? {30'h0, mode_r, 1'b0} :
    (addr_in == OFF_STATUS) ? {31'h0, busy} :
    (addr_in == OFF_CHAIN)  ? {26'h0, chain_r} : 32'h0;

  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      rdata_r <= 32'h0;
    else
      rdata_r <= rd_in ? rd_mux : 32'h0;
  end

  assign rdata_out = rdata_r;
  // Pin sharing by mode; half period sized from minimum clock period
  assign link.mode_serial   = mode_r;
  assign link.pin_22        = mode_r ? le_r : word_r[2];
  assign link.pin_23        = mode_r ? sck_r : word_r[1];
  assign link.pin_24        = mode_r ? sh_r[PHASE_W-1] : word_r[0];
  assign link.phase_bits_hi = mode_r ? 3'h0 : word_r[5:3];
endmodule : phase_shifter_host
`default_nettype wire

// ### dv/phase_shifter_chk.sv
`timescale 1ns/10ps
`default_nettype none
module phase_shifter_chk (
  // Clock and reset
  input wire logic       clk_sys_in,
  input wire logic       rst_b_in,
  // Link pins and phase
  input wire logic       mode_serial,
  input wire logic       pin_22,
  input wire logic       pin_23,
  input wire logic       pin_24,
  input wire logic [2:0] phase_bits_hi,
  input wire logic       shift_data_out,
  input wire logic [5:0] phase_state_out
);
  import phase_ctl_pkg::*;
  logic [5:0] shadow_r;
  logic       sck_r;
  logic       strb_r;
  logic [3:0] gap_r;
  logic [2:0] nbit_r;
  wire        shift_w = mode_serial && !pin_22 && pin_23 && !sck_r;
  wire        latch_w = mode_serial && pin_22 && !strb_r;
  //////////////////////////////////////////////////////////////////////
  // Shadow of the shift chain, seen at the pins without the sync delay
  always_ff @(posedge clk_sys_in or negedge rst_b_in)
    if (!rst_b_in)
    begin
      {shadow_r, sck_r, strb_r, nbit_r} <= '0;
      gap_r <= 4'hf;
    end
    else
    begin
      {sck_r, strb_r} <= {pin_23, pin_22};
      shadow_r <= shift_w ? {shadow_r[4:0], pin_24} : shadow_r;
      nbit_r <= latch_w ? 3'h0 : nbit_r + 3'((shift_w && nbit_r != 3'h7) ? 1 : 0);
      gap_r <= latch_w ? 4'h0 : gap_r + 4'((gap_r != 4'hf) ? 1 : 0);
    end
  //////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);
  a_parallel_follow: assert property (
    (!mode_serial && $stable({phase_bits_hi, pin_22, pin_23, pin_24}))[*5]
    |-> phase_state_out == {phase_bits_hi, pin_22, pin_23, pin_24}) else $error("parallel phase");
  a_serial_hold: assert property (
    (mode_serial && !pin_22)[*5] |-> $stable(phase_state_out)) else $error("phase moved");
  a_serial_off: assert property (
    (!mode_serial)[*6] |-> $stable(shift_data_out)) else $error("chain moved");
  a_latch_load: assert property (
    latch_w |-> ##[1:6] phase_state_out == shadow_r) else $error("latch load");
  a_chain_out: assert property (
    (mode_serial && $stable(shadow_r))[*6] |-> shift_data_out == shadow_r[5])
    else $error("chain out");
  a_word_count: assert property (
    latch_w |-> nbit_r == 3'h6) else $error("bit count");
  a_strobe_gap: assert property (
    latch_w |-> gap_r >= 4'h6) else $error("strobe gap");
  a_strobe_still: assert property (
    mode_serial && pin_22 && $past(pin_22) |-> $stable(pin_23)) else $error("clock in strobe");
endmodule : phase_shifter_chk
`default_nettype wire

// ### dv/test_phase_shifter_control_interface.sv
`timescale 1ns/10ps
`default_nettype none
module test_phase_shifter_control_interface;
  import phase_ctl_pkg::*;
  typedef struct packed {logic chk; logic [31:0] val;} note_t;
  logic        clk_sys_in = 1'b0;
  logic        rst_b_in = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        rd_r = 1'b0;
  logic [31:0] rdata;
  logic [5:0]  phase;
  logic [5:0]  ph_r = 6'h00;
  logic [5:0]  cur = 6'h00;
  logic [5:0]  last_w = 6'h00;
  logic [5:0]  exp_ph;
  logic [31:0] seed = 32'h6beb9e53;
  int          bad_count = 0;
  int          n_checks = 0;
  note_t       rq[$];
  logic [5:0]  pq[$];
  phase_ctl_if link ();
  phase_shifter_host phase_shifter_host_i (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
    .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
    .link(link.host));
  phase_shifter_device phase_shifter_device_i (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
    .link(link.device), .phase_state_out(phase));
  phase_shifter_chk phase_shifter_chk_i (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
    .mode_serial(link.mode_serial), .pin_22(link.pin_22), .pin_23(link.pin_23),
    .pin_24(link.pin_24), .phase_bits_hi(link.phase_bits_hi),
    .shift_data_out(link.shift_data_out), .phase_state_out(phase));
  always #50 clk_sys_in = ~clk_sys_in;
  //////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // One bus cycle; a read leaves its expected data for the monitor
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic c);
    @(posedge clk_sys_in);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    if (!w) rq.push_back('{c, d});
    @(posedge clk_sys_in);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus
  // Only real changes are noted, so a spurious phase move finds no note
  task automatic note(input logic [5:0] w);
    if (w !== cur) pq.push_back(w);
    cur = w;
  endtask : note
  task automatic load(input logic [5:0] w);
    logic busy;
    busy = 1'b1;
    bus(1'b1, OFF_WORD, {26'h0, w}, 1'b0);
    bus(1'b1, OFF_CTRL, 32'h3, 1'b0);
    note(w);
    for (int n = 0; n < 100 && busy; n++)
    begin
      bus(1'b0, OFF_STATUS, 32'h0, 1'b0);
      #1 busy = rdata[0];
    end
    check({31'h0, busy}, 32'h0, "busy");
    // The chain hands back the word shifted in by the frame before
    bus(1'b0, OFF_CHAIN, {26'h0, last_w}, 1'b1);
    last_w = w;
  endtask : load
  //////////////////////////////////////////////////////////////////////
  // Monitor: read data the cycle after the strobe, phase on every change
  always @(posedge clk_sys_in)
  begin
    rd_r <= rd;
    ph_r <= phase;
    if (rd_r && rq.size() > 0 && rq[0].chk) check(rdata, rq[0].val, "rdata");
    if (rd_r && rq.size() > 0) void'(rq.pop_front());
    if (rst_b_in && ph_r !== phase)
    begin
      exp_ph = (pq.size() > 0) ? pq.pop_front() : ~phase;
      check({26'h0, phase}, {26'h0, exp_ph}, "phase");
    end
  end
  initial
  begin
    #1_000_000;
    bad_count++;
    end_of_test();
  end
  initial
  begin
    repeat (3) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    bus(1'b0, OFF_CTRL, 32'h2, 1'b1);
    bus(1'b0, 4'h2, 32'h0, 1'b1);
    // Boundaries, then random words, shifted in back to back
    foreach (pq[i]) void'(pq.pop_front());
    for (int i = 0; i < 12; i++)
    begin
      seed = lfsr(seed);
      load(i == 0 ? 6'h3f : i == 1 ? 6'h00 : i == 2 ? 6'h01 : i == 3 ? 6'h20 : seed[5:0]);
    end
    // Parallel mode: walking one, then random words
    bus(1'b1, OFF_CTRL, 32'h0, 1'b0);
    for (int i = 0; i < 12; i++)
    begin
      seed = lfsr(seed);
      bus(1'b1, OFF_WORD, {26'h0, i < 6 ? 6'h01 << i : seed[5:0]}, 1'b0);
      note(i < 6 ? 6'h01 << i : seed[5:0]);
      repeat (8) @(posedge clk_sys_in);
    end
    // Back to serial without a latch keeps the phase
    bus(1'b1, OFF_CTRL, 32'h2, 1'b0);
    repeat (10) @(posedge clk_sys_in);
    load(6'h2d);
    // Reset in mid-run
    @(posedge clk_sys_in);
    rst_b_in <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    cur = 6'h00;
    last_w = 6'h00;
    #1 check({26'h0, phase}, 32'h0, "phase reset");
    load(6'h3e);
    repeat (5) @(posedge clk_sys_in);
    check(pq.size(), 32'h0, "notes left");
    end_of_test();
  end
endmodule : test_phase_shifter_control_interface
`default_nettype wire
